// [verilog/timer_io_pkg.sv]
// Constants shared by the timer pin I/O control block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package timer_io_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_SEL_CH4 = 5'h00;
  localparam logic [4:0] OFS_SEL_CH5 = 5'h04;
  localparam logic [4:0] OFS_SEL_CH0 = 5'h08;
  localparam logic [4:0] OFS_GR_CH4 = 5'h0c;
  localparam logic [4:0] OFS_GR_CH5 = 5'h10;
  localparam logic [4:0] OFS_GR_CH0 = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  // Field positions
  localparam int FIELD_B_LSB = 4;
  localparam int FIELD_A_LSB = 0;
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_IN_LSB = 4;
  // Reset values
  localparam logic [7:0] RESET_SEL = 8'h00;
  localparam logic [15:0] RESET_GR = 16'h0000;
  // Count clock select code for divide-by-one
  localparam logic [2:0] CLK_SEL_DIV1 = 3'h0;
  // Output action at compare match, from the two low field bits
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_LOW,
    ACT_HIGH,
    ACT_TOGGLE
  } match_action_t;
endpackage

// [verilog/timer_pin_channel.sv]
// One timer channel: general register, compare output and capture.
// Assumes pin_level is already synchronised to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module timer_pin_channel
  import timer_io_pkg::*;
#(
  parameter int GR_WIDTH = 16,
  parameter bit HAS_CASCADE = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] mode,
  input wire logic mode_write,
  input wire logic [GR_WIDTH-1:0] count,
  input wire logic count_tick,
  input wire logic gr_write,
  input wire logic [GR_WIDTH-1:0] gr_wdata,
  input wire logic pin_level,
  input wire logic cascade_event,
  output logic [GR_WIDTH-1:0] gr_value,
  output logic pin_out,
  output logic pin_oe_n,
  output logic capture
);
  logic pin_prev;
  logic next_pin;

  // Mode decode and event detection
  wire is_capture = mode[3];
  wire out_enabled = ~mode[3] & (mode[1:0] != 2'b00);
  wire use_cascade = HAS_CASCADE & mode[2];
  wire rise = pin_level & ~pin_prev;
  wire fall = ~pin_level & pin_prev;
  wire edge_hit = mode[1] ? (rise | fall) : (mode[0] ? fall : rise);
  wire cap_event = is_capture & (use_cascade ? cascade_event : edge_hit);
  wire match = ~is_capture & count_tick & (count == gr_value);
  wire match_action_t action = match_action_t'(mode[1:0]);

  // Pin level: new mode loads the initial level, a match acts on it
  always_comb begin
    next_pin = pin_out;
    if (mode_write && out_enabled) begin
      next_pin = mode[2];
    end else if (match) begin
      unique case (action)
        ACT_NONE: next_pin = pin_out;
        ACT_LOW: next_pin = 1'b0;
        ACT_HIGH: next_pin = 1'b1;
        ACT_TOGGLE: next_pin = ~pin_out;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      pin_prev <= 1'b0;
    end else begin
      pin_out <= next_pin;
      pin_oe_n <= ~out_enabled;
      pin_prev <= pin_level;
    end
  end

  // Capture wins over a bus write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gr_value <= RESET_GR;
      capture <= 1'b0;
    end else begin
      capture <= cap_event;
      if (cap_event) begin
        gr_value <= count;
      end else if (gr_write) begin
        gr_value <= gr_wdata;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_low_at_match;
    (match && mode[1:0] == 2'b01 && !mode_write) |=> !pin_out;
  endproperty
  a_low_at_match: assert property (p_low_at_match) else $error("pin not low");

  property p_high_at_match;
    (match && mode[1:0] == 2'b10 && !mode_write) |=> pin_out;
  endproperty
  a_high_at_match: assert property (p_high_at_match) else $error("pin not high");

  property p_toggle_at_match;
    (match && mode[1:0] == 2'b11 && !mode_write) |=> (pin_out != $past(pin_out));
  endproperty
  a_toggle_at_match: assert property (p_toggle_at_match) else $error("no toggle");

  property p_cap_rise;
    (mode == 4'b1000 && rise) |=> (capture && gr_value == $past(count));
  endproperty
  a_cap_rise: assert property (p_cap_rise) else $error("rise not captured");

  property p_cap_fall;
    (mode == 4'b1001 && fall) |=> (capture && gr_value == $past(count));
  endproperty
  a_cap_fall: assert property (p_cap_fall) else $error("fall not captured");

  property p_cap_both;
    (mode[3] && mode[1] && !use_cascade && (rise || fall)) |=> capture;
  endproperty
  a_cap_both: assert property (p_cap_both) else $error("edge not captured");

  property p_initial_level;
    (mode_write && out_enabled) |=> (pin_out == $past(mode[2]) && !pin_oe_n);
  endproperty
  a_initial_level: assert property (p_initial_level) else $error("bad initial");

  property p_disabled;
    (mode == 4'b0000 || mode == 4'b0100) ##1 $stable(mode) |-> pin_oe_n;
  endproperty
  a_disabled: assert property (p_disabled) else $error("pin not disabled");
endmodule
`default_nettype wire

// [verilog/timer_pin_io_control.sv]
// Pin I/O control for timer channels 4 and 5 (register B) and 0 (A).
// Assumes counters and cascade events come from logic on sys_clk;
// only the timer pins arrive asynchronously.
//
// Overview of operation
// - Output compare low bits 01: pin driven low at each match.
// - Output compare low bits 10: pin driven high at each match.
// - Output compare low bits 11: pin inverted at each match.
// - Code 1000 captures the counter on a rising source edge.
// - Code 1001 captures the counter on a falling source edge.
// - Codes 101x capture on both edges; channel 5 ignores bit 2.
// - Channel 4 codes 11xx capture on channel 3 register C events.
// - Channel 0 codes 1000 to 101x capture from its own pin.
// - Channel 0 codes 11xx capture on channel 1 count up or down.
// - Channel 1 on divide-by-one clock: channel 0 cascade capture never fires.
`timescale 1ns/1ns
`default_nettype none
module timer_pin_io_control
  import timer_io_pkg::*;
#(
  parameter int GR_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [GR_WIDTH-1:0] ch4_count,
  input wire logic ch4_count_tick,
  input wire logic [GR_WIDTH-1:0] ch5_count,
  input wire logic ch5_count_tick,
  input wire logic [GR_WIDTH-1:0] ch0_count,
  input wire logic ch0_count_tick,
  input wire logic ch3_regc_event,
  input wire logic ch1_count_up,
  input wire logic ch1_count_down,
  input wire logic [2:0] ch1_clock_select,
  input wire logic ch4_pin_b_in,
  output logic ch4_pin_b_out,
  output logic ch4_pin_b_oe_n,
  input wire logic ch5_pin_b_in,
  output logic ch5_pin_b_out,
  output logic ch5_pin_b_oe_n,
  input wire logic ch0_pin_a_in,
  output logic ch0_pin_a_out,
  output logic ch0_pin_a_oe_n,
  output logic ch4_capture,
  output logic ch5_capture,
  output logic ch0_capture
);
  logic [7:0] io_select_ch4;
  logic [7:0] io_select_ch5;
  logic [7:0] io_select_ch0_high;
  logic [2:0] sel_written;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [GR_WIDTH-1:0] ch4_general_reg_b;
  logic [GR_WIDTH-1:0] ch5_general_reg_b;
  logic [GR_WIDTH-1:0] ch0_general_reg_a;

  // Pin inputs, index 0 = ch4, 1 = ch5, 2 = ch0
  wire [2:0] pin_raw = {ch0_pin_a_in, ch5_pin_b_in, ch4_pin_b_in};
  wire [2:0] pin_level_out = {ch0_pin_a_out, ch5_pin_b_out, ch4_pin_b_out};

  // Two-stage synchronisers; stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // Channel mode fields
  wire [3:0] regb_mode_ch4 = io_select_ch4[FIELD_B_LSB +: 4];
  wire [3:0] regb_mode_ch5 = io_select_ch5[FIELD_B_LSB +: 4];
  wire [3:0] rega_mode_ch0 = io_select_ch0_high[FIELD_A_LSB +: 4];

  // Cascade sources; divide-by-one clocking blocks channel 1 steps
  wire ch1_div1 = (ch1_clock_select == CLK_SEL_DIV1);
  wire ch1_step = (ch1_count_up | ch1_count_down) & ~ch1_div1;

  // Bus decode; one wait state on every access
  wire bus_req = avs_read | avs_write;
  wire bus_take = bus_req & avs_waitrequest;
  wire wr_take = avs_write & ~avs_waitrequest;
  wire [4:0] word_addr = {avs_address[4:2], 2'b00};
  wire hit_sel4 = (word_addr == OFS_SEL_CH4);
  wire hit_sel5 = (word_addr == OFS_SEL_CH5);
  wire hit_sel0 = (word_addr == OFS_SEL_CH0);
  wire hit_gr4 = (word_addr == OFS_GR_CH4);
  wire hit_gr5 = (word_addr == OFS_GR_CH5);
  wire hit_gr0 = (word_addr == OFS_GR_CH0);
  wire hit_stat = (word_addr == OFS_STATUS);
  wire [GR_WIDTH-1:0] gr_wdata = avs_writedata[GR_WIDTH-1:0];

  // Status: driven pin levels and synchronised pin inputs
  wire [31:0] status_word = (32'(pin_level_out) << STAT_OUT_LSB)
                          | (32'(pin_sync) << STAT_IN_LSB);

  // Read selection; unmapped words read as zero
  wire [31:0] rd_mux =
      hit_sel4 ? {24'h000000, io_select_ch4} :
      hit_sel5 ? {24'h000000, io_select_ch5} :
      hit_sel0 ? {24'h000000, io_select_ch0_high} :
      hit_gr4 ? 32'(ch4_general_reg_b) :
      hit_gr5 ? 32'(ch5_general_reg_b) :
      hit_gr0 ? 32'(ch0_general_reg_a) :
      hit_stat ? status_word : 32'h00000000;

  // Handshake: waitrequest drops for one cycle per request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~bus_take;
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Select registers; the write pulse is delayed so that the
  // channel sees the new mode and the pulse together
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      io_select_ch4 <= RESET_SEL;
      io_select_ch5 <= RESET_SEL;
      io_select_ch0_high <= RESET_SEL;
      sel_written <= 3'h0;
    end else begin
      sel_written <= {wr_take & hit_sel0, wr_take & hit_sel5, wr_take & hit_sel4};
      if (wr_take && hit_sel4) begin
        io_select_ch4 <= avs_writedata[7:0];
      end
      if (wr_take && hit_sel5) begin
        io_select_ch5 <= avs_writedata[7:0];
      end
      if (wr_take && hit_sel0) begin
        io_select_ch0_high <= avs_writedata[7:0];
      end
    end
  end

  // Channel 4: cascade from channel 3 register C
  timer_pin_channel #(
    .GR_WIDTH(GR_WIDTH),
    .HAS_CASCADE(1'b1)
  ) u_ch4 (
    .sys_clk(sys_clk),
    .reset(reset),
    .mode(regb_mode_ch4),
    .mode_write(sel_written[0]),
    .count(ch4_count),
    .count_tick(ch4_count_tick),
    .gr_write(wr_take & hit_gr4),
    .gr_wdata(gr_wdata),
    .pin_level(pin_sync[0]),
    .cascade_event(ch3_regc_event),
    .gr_value(ch4_general_reg_b),
    .pin_out(ch4_pin_b_out),
    .pin_oe_n(ch4_pin_b_oe_n),
    .capture(ch4_capture)
  );

  // Channel 5: no cascade, so bit 2 is ignored in capture mode
  timer_pin_channel #(
    .GR_WIDTH(GR_WIDTH),
    .HAS_CASCADE(1'b0)
  ) u_ch5 (
    .sys_clk(sys_clk),
    .reset(reset),
    .mode(regb_mode_ch5),
    .mode_write(sel_written[1]),
    .count(ch5_count),
    .count_tick(ch5_count_tick),
    .gr_write(wr_take & hit_gr5),
    .gr_wdata(gr_wdata),
    .pin_level(pin_sync[1]),
    .cascade_event(1'b0),
    .gr_value(ch5_general_reg_b),
    .pin_out(ch5_pin_b_out),
    .pin_oe_n(ch5_pin_b_oe_n),
    .capture(ch5_capture)
  );

  // Channel 0: own pin for 10xx, channel 1 steps for 11xx
  timer_pin_channel #(
    .GR_WIDTH(GR_WIDTH),
    .HAS_CASCADE(1'b1)
  ) u_ch0 (
    .sys_clk(sys_clk),
    .reset(reset),
    .mode(rega_mode_ch0),
    .mode_write(sel_written[2]),
    .count(ch0_count),
    .count_tick(ch0_count_tick),
    .gr_write(wr_take & hit_gr0),
    .gr_wdata(gr_wdata),
    .pin_level(pin_sync[2]),
    .cascade_event(ch1_step),
    .gr_value(ch0_general_reg_a),
    .pin_out(ch0_pin_a_out),
    .pin_oe_n(ch0_pin_a_oe_n),
    .capture(ch0_capture)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_ch4_cascade;
    (regb_mode_ch4[3:2] == 2'b11 && ch3_regc_event)
      |=> (ch4_capture && ch4_general_reg_b == $past(ch4_count));
  endproperty
  a_ch4_cascade: assert property (p_ch4_cascade) else $error("ch4 missed cascade");

  property p_ch4_no_pin;
    (regb_mode_ch4[3:2] == 2'b11 && !ch3_regc_event) |=> !ch4_capture;
  endproperty
  a_ch4_no_pin: assert property (p_ch4_no_pin) else $error("ch4 stray capture");

  property p_ch0_own_pin;
    (rega_mode_ch0 == 4'b1010 && $changed(pin_sync[2])) |=> ch0_capture;
  endproperty
  a_ch0_own_pin: assert property (p_ch0_own_pin) else $error("ch0 pin missed");

  property p_ch0_pin_only;
    (rega_mode_ch0[3:2] == 2'b10 && $stable(pin_sync[2])) |=> !ch0_capture;
  endproperty
  a_ch0_pin_only: assert property (p_ch0_pin_only) else $error("ch0 stray capture");

  property p_ch0_cascade;
    (rega_mode_ch0[3:2] == 2'b11 && !ch1_div1 && (ch1_count_up || ch1_count_down))
      |=> (ch0_capture && ch0_general_reg_a == $past(ch0_count));
  endproperty
  a_ch0_cascade: assert property (p_ch0_cascade) else $error("ch0 missed step");

  property p_ch0_div1;
    (rega_mode_ch0[3:2] == 2'b11 && ch1_div1) |=> !ch0_capture;
  endproperty
  a_ch0_div1: assert property (p_ch0_div1) else $error("div1 capture fired");

  property p_bus_answer;
    (bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bad handshake");

  // Capture and disabled codes leave the pin to the outside world
  property p_ch5_released;
    (regb_mode_ch5[3] || regb_mode_ch5[1:0] == 2'b00) |=> ch5_pin_b_oe_n;
  endproperty
  a_ch5_released: assert property (p_ch5_released) else $error("ch5 pin driven");

  // No cascade source on channel 5, so bit 2 set still means a pin edge
  property p_ch5_bit2;
    (regb_mode_ch5[3:2] == 2'b11 && regb_mode_ch5[1] && $changed(pin_sync[1]))
      |=> (ch5_capture && ch5_general_reg_b == $past(ch5_count));
  endproperty
  a_ch5_bit2: assert property (p_ch5_bit2) else $error("ch5 missed");

  // A select write lands at the edge where waitrequest is seen low
  property p_sel_write;
    (avs_write && !avs_waitrequest && hit_sel4)
      |=> (io_select_ch4 == $past(avs_writedata[7:0]));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write lost");

  // Main scenarios
  property p_cov_toggle;
    (regb_mode_ch4 == 4'b0011 && ch4_count_tick) ##1 $changed(ch4_pin_b_out);
  endproperty
  c_cov_toggle: cover property (p_cov_toggle);

  property p_cov_cascade4;
    (regb_mode_ch4[3:2] == 2'b11) ##1 ch4_capture;
  endproperty
  c_cov_cascade4: cover property (p_cov_cascade4);

  property p_cov_both5;
    (regb_mode_ch5 == 4'b1110) ##1 ch5_capture;
  endproperty
  c_cov_both5: cover property (p_cov_both5);

  property p_cov_step0;
    (rega_mode_ch0[3:2] == 2'b11 && ch1_step) ##1 ch0_capture;
  endproperty
  c_cov_step0: cover property (p_cov_step0);

  property p_cov_div1;
    (rega_mode_ch0[3:2] == 2'b11 && ch1_div1 && ch1_count_up);
  endproperty
  c_cov_div1: cover property (p_cov_div1);
endmodule
`default_nettype wire

// [verification/timer_far_side.sv]
// Far side of the timer pins: counter source and resolved pin wires.
// Assumes the bench commands run and the outside pin levels.
`timescale 1ns/1ns
`default_nettype none
module timer_far_side (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [2:0] ext_level,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  output logic [15:0] count,
  output logic tick,
  output logic [2:0] pin_level
);
  // Eight-bit wrap keeps compare waits short
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count <= 16'h0000;
    end else if (run) begin
      count <= {8'h00, count[7:0] + 8'h01};
    end
  end
  // Frozen counter gives no tick, so no stray match
  assign tick = run;
  // Device wins the wire while it drives
  assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule
`default_nettype wire

// [verification/timer_pin_io_control_bench.sv]
// Self-checking bench for the timer pin I/O control block.
// Assumes the far side model drives counters and pin wires.
`timescale 1ns/1ns
`default_nettype none
module timer_pin_io_control_bench
  import timer_io_pkg::*;
();
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic ch3_regc_event = 1'b0;
  logic ch1_count_up = 1'b0;
  logic ch1_count_down = 1'b0;
  logic [2:0] ch1_clock_select = 3'h1;
  logic run = 1'b0;
  logic [2:0] ext_level = 3'h0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic [15:0] count;
  wire logic tick;
  wire logic [2:0] pin_level, pout, poe, caps;
  int err_count = 0;
  int checks_done = 0;
  localparam logic [4:0] sel_ofs [3] = '{OFS_SEL_CH4, OFS_SEL_CH5, OFS_SEL_CH0};
  localparam logic [4:0] gr_ofs [3] = '{OFS_GR_CH4, OFS_GR_CH5, OFS_GR_CH0};

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  timer_pin_io_control uut (
    .sys_clk(sys_clk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ch4_count(count),
    .ch4_count_tick(tick),
    .ch5_count(count),
    .ch5_count_tick(tick),
    .ch0_count(count),
    .ch0_count_tick(tick),
    .ch3_regc_event(ch3_regc_event),
    .ch1_count_up(ch1_count_up),
    .ch1_count_down(ch1_count_down),
    .ch1_clock_select(ch1_clock_select),
    .ch4_pin_b_in(pin_level[0]),
    .ch4_pin_b_out(pout[0]),
    .ch4_pin_b_oe_n(poe[0]),
    .ch5_pin_b_in(pin_level[1]),
    .ch5_pin_b_out(pout[1]),
    .ch5_pin_b_oe_n(poe[1]),
    .ch0_pin_a_in(pin_level[2]),
    .ch0_pin_a_out(pout[2]),
    .ch0_pin_a_oe_n(poe[2]),
    .ch4_capture(caps[0]),
    .ch5_capture(caps[1]),
    .ch0_capture(caps[2])
  );

  timer_far_side far (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(run),
    .ext_level(ext_level),
    .pin_out(pout),
    .pin_oe_n(poe),
    .count(count),
    .tick(tick),
    .pin_level(pin_level)
  );

  // Verdict and end of run
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  // One transfer, held until waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      chk("waitrequest", 32'h0, 32'h1);
      finish_test();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(nm, e, q);
  endtask

  // Channel 0 field sits low, the B channels high
  function automatic logic [31:0] field(input int ch, input logic [3:0] c);
    return (ch == 2) ? {28'h0, c} : {24'h0, c, 4'h0};
  endfunction

  // Eight edges cover the pin synchroniser; counter is frozen meanwhile
  task automatic watch(input int ch, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      if (caps[ch] === 1'b1) seen = 1'b1;
    end
    chk("capture", {31'h0, exp}, {31'h0, seen});
    if (exp) rd_chk("captured_value", gr_ofs[ch], {16'h0, count});
  endtask

  task automatic pin_cap(input int ch, input logic [3:0] c, input logic from,
      input logic to, input logic exp);
    @(posedge sys_clk);
    run <= 1'b1;
    ext_level[ch] <= from;
    @(posedge sys_clk);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(sel_ofs[ch], field(ch, c));
    repeat (4) @(posedge sys_clk);
    ext_level[ch] <= to;
    watch(ch, exp);
  endtask

  task automatic pulse(input int w);
    @(posedge sys_clk);
    if (w == 0) ch3_regc_event <= 1'b1;
    if (w == 1) ch1_count_up <= 1'b1;
    if (w == 2) ch1_count_down <= 1'b1;
    @(posedge sys_clk);
    {ch3_regc_event, ch1_count_up, ch1_count_down} <= 3'h0;
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset_value", 5'(i * 4), 32'h0);
    end
    wr(sel_ofs[1], 32'h0000003c);
    rd_chk("io_select_ch5", sel_ofs[1], 32'h0000003c);
    wr(OFS_STATUS, 32'h000000ff);
    rd_chk("status", OFS_STATUS, 32'h0);
  endtask

  // Every output code on every channel, initial level then one match
  task automatic t_compare();
    logic [3:0] c;
    int n;
    for (int ch = 0; ch < 3; ch++) begin
      wr(gr_ofs[ch], 32'h00000080);
      rd_chk("general_reg", gr_ofs[ch], 32'h00000080);
      for (int k = 0; k < 8; k++) begin
        c = 4'(k);
        wr(sel_ofs[ch], field(ch, c));
        repeat (2) @(posedge sys_clk);
        chk("pin_oe_n", {31'h0, c[1:0] == 2'h0}, {31'h0, poe[ch]});
        if (c[1:0] != 2'h0) begin
          chk("initial_level", {31'h0, c[2]}, {31'h0, pout[ch]});
          run <= 1'b1;
          n = 0;
          do begin
            @(posedge sys_clk);
            n++;
          end while (count !== 16'h0080 && n < 300);
          @(posedge sys_clk);
          run <= 1'b0;
          if (n >= 300) begin
            chk("match_wait", 32'h0, 32'h1);
            finish_test();
          end
          chk("match_level", {31'h0, c[1:0] == 2'h2 | (c[1:0] == 2'h3 & ~c[2])},
              {31'h0, pout[ch]});
        end
      end
    end
  endtask

  task automatic t_pin();
    pin_cap(0, 4'h8, 1'b0, 1'b1, 1'b1);
    pin_cap(0, 4'h8, 1'b1, 1'b0, 1'b0);
    pin_cap(0, 4'h9, 1'b1, 1'b0, 1'b1);
    pin_cap(0, 4'h9, 1'b0, 1'b1, 1'b0);
    pin_cap(1, 4'ha, 1'b0, 1'b1, 1'b1);
    pin_cap(1, 4'hb, 1'b1, 1'b0, 1'b1);
    pin_cap(1, 4'he, 1'b0, 1'b1, 1'b1);
    pin_cap(1, 4'hc, 1'b1, 1'b0, 1'b0);
    pin_cap(2, 4'h8, 1'b0, 1'b1, 1'b1);
    pin_cap(2, 4'hb, 1'b1, 1'b0, 1'b1);
    pin_cap(0, 4'hc, 1'b0, 1'b1, 1'b0);
    pin_cap(2, 4'hc, 1'b1, 1'b0, 1'b0);
    rd_chk("status_pins", OFS_STATUS, 32'(ext_level) << STAT_IN_LSB);
  endtask

  task automatic t_cascade();
    wr(sel_ofs[0], field(0, 4'hd));
    pulse(0);
    watch(0, 1'b1);
    pulse(1);
    watch(0, 1'b0);
    wr(sel_ofs[2], field(2, 4'hc));
    pulse(1);
    watch(2, 1'b1);
    pulse(2);
    watch(2, 1'b1);
    pulse(0);
    watch(2, 1'b0);
    ch1_clock_select <= CLK_SEL_DIV1;
    pulse(1);
    watch(2, 1'b0);
    pulse(2);
    watch(2, 1'b0);
  endtask

  // Reset for 16 cycles, then the scenarios
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_compare();
    t_pin();
    t_cascade();
    finish_test();
  end
endmodule
`default_nettype wire
